/* File: common/fiap_pkg.sv */
/*
 * Package for the flash self-programming register block: register indices,
 * control field positions, unlock pattern, timer figure and the flash-side request and write-buffer carriers.
 * Assumes a 10 MHz system clock and an 8-bit special-function register port.
 */
package fiap_pkg;
   // Register indices on the special-function register port
   localparam logic [3:0] FIAP_IDX_ADDR_LOW  = 4'h0;
   localparam logic [3:0] FIAP_IDX_ADDR_HIGH = 4'h1;
   localparam logic [3:0] FIAP_IDX_W0_LOW    = 4'h2;
   localparam logic [3:0] FIAP_IDX_W0_HIGH   = 4'h3;
   localparam logic [3:0] FIAP_IDX_W1_LOW    = 4'h4;
   localparam logic [3:0] FIAP_IDX_W1_HIGH   = 4'h5;
   localparam logic [3:0] FIAP_IDX_W2_LOW    = 4'h6;
   localparam logic [3:0] FIAP_IDX_W2_HIGH   = 4'h7;
   localparam logic [3:0] FIAP_IDX_W3_LOW    = 4'h8;
   localparam logic [3:0] FIAP_IDX_W3_HIGH   = 4'h9;
   localparam logic [3:0] FIAP_IDX_MODE_CTRL = 4'ha;
   localparam logic [3:0] FIAP_IDX_BUF_CTRL  = 4'hb;

   // Mode/control register fields
   localparam int FIAP_BIT_UNLOCK_STATUS  = 7;
   localparam int FIAP_BIT_MODE_LSB       = 4;
   localparam int FIAP_BIT_UNLOCK_TRIGGER = 3;
   localparam int FIAP_BIT_WRITE_INIT     = 2;
   localparam int FIAP_BIT_READ_ENABLE    = 1;
   localparam int FIAP_BIT_READ_INIT      = 0;

   // Buffer control register fields
   localparam int FIAP_BIT_BUF_RSV7  = 7;
   localparam int FIAP_BIT_BUF_RO6   = 6;
   localparam int FIAP_BIT_BUF_RSV4  = 4;
   localparam int FIAP_BIT_BUF_CLEAR = 0;

   localparam logic [7:0] FIAP_RESET_VAL = 8'h00;

   // Operation mode encodings
   localparam logic [2:0] FIAP_MODE_WRITE  = 3'h0;
   localparam logic [2:0] FIAP_MODE_ERASE  = 3'h1;
   localparam logic [2:0] FIAP_MODE_READ   = 3'h3;
   localparam logic [2:0] FIAP_MODE_UNLOCK = 3'h6;

   // Unlock pattern for words 1..3, low bytes then high bytes
   localparam logic [7:0] FIAP_KEY_W1_LOW  = 8'h00;
   localparam logic [7:0] FIAP_KEY_W2_LOW  = 8'h0d;
   localparam logic [7:0] FIAP_KEY_W3_LOW  = 8'hc3;
   localparam logic [7:0] FIAP_KEY_W1_HIGH = 8'h04;
   localparam logic [7:0] FIAP_KEY_W2_HIGH = 8'h09;
   localparam logic [7:0] FIAP_KEY_W3_HIGH = 8'h40;

   // Unlock window
   localparam int FIAP_CLK_HZ          = 10_000_000;
   localparam int FIAP_UNLOCK_US       = 1000;
   localparam int FIAP_UNLOCK_CYCLES   = (FIAP_CLK_HZ / 1_000_000) * FIAP_UNLOCK_US;

   typedef enum logic [1:0] {
      FIAP_OP_NONE,
      FIAP_OP_WRITE,
      FIAP_OP_ERASE,
      FIAP_OP_READ
   } fiap_op_t;

   // Request toward the flash array macro
   typedef struct packed {
      logic        start;
      fiap_op_t    op;
      logic [14:0] addr;
   } fiap_flash_req_t;

   // Write buffer load toward the flash array macro
   typedef struct packed {
      logic        load;
      logic        clear;
      logic [5:0]  index;
      logic [15:0] data;
   } fiap_wbuf_t;
endpackage : fiap_pkg

/* File: verilog/fiap_regs.sv */
/*
 * Flash self-programming register block: address, data words, mode/control
 * and buffer-control registers, unlock timer and operation sequencing.
 * Assumes the flash array macro answers each started operation with a
 * one-cycle done pulse, and that register accesses are synchronous to clk.
 */
// Notes on behaviour
// RULE_01 - High address holds variant bits, rest zero
// RULE_02 - Word0 low write only stores byte
// RULE_03 - Word0 high write loads buffer, increments
// RULE_04 - Status ignores one, zero clears it
// RULE_05 - Status set only on successful unlock
// RULE_06 - Mode field decodes write, erase, read, unlock
// RULE_07 - Software unlocks before erase or write
// RULE_08 - Trigger starts timer, cleared after 1ms
// RULE_09 - Software writes pattern within 1ms window
// RULE_10 - Write initiate starts op, self clears
// RULE_11 - Processor stalls while write/read initiate
// RULE_12 - Reads proceed only with read enable
// RULE_13 - Read initiate starts read, self clears
// RULE_14 - Software never sets three bits together
// RULE_15 - Buffer control reserved bits read rules
// RULE_16 - Buffer clear bit self clears when done
// RULE_17 - Words one to three read/write, reset zero
// RULE_18 - Unlock pattern 00 0D C3 04 09 40
// RULE_19 - Write completion clears write buffer
// RULE_20 - Address increment stops at page end
// RULE_21 - Locked write or erase leaves flash untouched
// RULE_22 - Pattern counts only inside timer window
module fiap_regs
   import fiap_pkg::*;
#(
   parameter int ADDR_HIGH_BITS = 5,
   parameter int PAGE_BITS      = 5,
   parameter int UNLOCK_CYCLES  = FIAP_UNLOCK_CYCLES
) (
   input  wire logic            clk,
   input  wire logic            rst_b,
   input  wire logic            clk_en,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   input  wire logic [3:0]      reg_idx,
   input  wire logic [7:0]      reg_wdata,
   output      logic [7:0]      reg_rdata,
   input  wire logic            flash_done,
   input  wire logic [15:0]     flash_rdata,
   output      fiap_flash_req_t flash_req,
   output      fiap_wbuf_t      wbuf,
   output      logic            cpu_stall
);
   initial begin
      if (ADDR_HIGH_BITS < 5 || ADDR_HIGH_BITS > 7) $error("ADDR_HIGH_BITS must be 5..7");
      if (PAGE_BITS != 5 && PAGE_BITS != 6) $error("PAGE_BITS must be 5 or 6");
      if (UNLOCK_CYCLES < 2 || UNLOCK_CYCLES > 2**24) $error("UNLOCK_CYCLES out of range");
   end

   localparam int ADDR_W = 8 + ADDR_HIGH_BITS;

   ////////////////////////////////////////////////////////////////////////////
   // Reset synchroniser
   logic rst_s1_reg;
   logic rst_s2_reg;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end
   wire logic rst_n = rst_s2_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   logic [ADDR_W-1:0] addr_reg;
   logic [7:0]        data_low_reg  [4];
   logic [7:0]        data_high_reg [4];
   logic              unlock_status_reg;
   logic [2:0]        mode_reg;
   logic              unlock_trigger_reg;
   logic              write_initiate_reg;
   logic              read_enable_reg;
   logic              read_initiate_reg;
   logic              buf_rsv7_reg;
   logic              buf_rsv4_reg;
   logic              buffer_clear_reg;
   logic [23:0]       timer_reg;
   logic              busy_reg;

   wire logic wr_en   = clk_en && reg_wr;
   wire logic wr_mode = wr_en && reg_idx == FIAP_IDX_MODE_CTRL;
   wire logic wr_w0h  = wr_en && reg_idx == FIAP_IDX_W0_HIGH;
   wire logic [PAGE_BITS-1:0] page_off = addr_reg[PAGE_BITS-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // Address and data registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_reg <= '0;
      end else if (wr_en && reg_idx == FIAP_IDX_ADDR_LOW) begin
         addr_reg[7:0] <= reg_wdata;
      end else if (wr_en && reg_idx == FIAP_IDX_ADDR_HIGH) begin
         // RULE_01 only variant bits stored
         addr_reg[ADDR_W-1:8] <= reg_wdata[ADDR_HIGH_BITS-1:0];
      end else if (wr_w0h && page_off != {PAGE_BITS{1'b1}}) begin
         // RULE_03 RULE_20 increment within page
         addr_reg <= addr_reg + ADDR_W'(1);
      end
   end

   // RULE_02 RULE_17 word registers plain storage, word 0 also takes flash read data
   for (genvar w = 0; w < 4; w++) begin : g_word
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            data_low_reg[w]  <= FIAP_RESET_VAL;
            data_high_reg[w] <= FIAP_RESET_VAL;
         end else if (clk_en && w == 0 && busy_reg && flash_done && flash_req.op == FIAP_OP_READ) begin
            data_low_reg[w]  <= flash_rdata[7:0];
            data_high_reg[w] <= flash_rdata[15:8];
         end else if (wr_en && reg_idx == 4'(FIAP_IDX_W0_LOW + 2*w)) begin
            data_low_reg[w] <= reg_wdata;
         end else if (wr_en && reg_idx == 4'(FIAP_IDX_W0_HIGH + 2*w)) begin
            data_high_reg[w] <= reg_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Unlock timer and status
   // RULE_18 pattern compare
   wire logic key_ok = data_low_reg[1] == FIAP_KEY_W1_LOW && data_low_reg[2] == FIAP_KEY_W2_LOW
                    && data_low_reg[3] == FIAP_KEY_W3_LOW && data_high_reg[1] == FIAP_KEY_W1_HIGH
                    && data_high_reg[2] == FIAP_KEY_W2_HIGH && data_high_reg[3] == FIAP_KEY_W3_HIGH;
   wire logic timeout = unlock_trigger_reg && timer_reg == 24'(UNLOCK_CYCLES - 1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_reg          <= '0;
         unlock_trigger_reg <= 1'b0;
      end else if (clk_en) begin
         if (timeout) begin
            // RULE_08 hardware clears trigger
            unlock_trigger_reg <= 1'b0;
            timer_reg          <= '0;
         end else if (unlock_trigger_reg) begin
            timer_reg <= timer_reg + 24'h000001;
         end else if (wr_mode && reg_wdata[FIAP_BIT_UNLOCK_TRIGGER]) begin
            // RULE_08 trigger starts timer
            unlock_trigger_reg <= 1'b1;
            timer_reg          <= '0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         unlock_status_reg <= 1'b0;
      end else if (clk_en) begin
         if (unlock_trigger_reg && mode_reg == FIAP_MODE_UNLOCK && key_ok) begin
            // RULE_05 RULE_22 set inside window, wins
            unlock_status_reg <= 1'b1;
         end else if (wr_mode && !reg_wdata[FIAP_BIT_UNLOCK_STATUS]) begin
            // RULE_04 zero clears, one ignored
            unlock_status_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode and operation control
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg        <= 3'h0;
         read_enable_reg <= 1'b0;
      end else if (wr_mode) begin
         mode_reg        <= reg_wdata[FIAP_BIT_MODE_LSB +: 3];
         read_enable_reg <= reg_wdata[FIAP_BIT_READ_ENABLE];
      end
   end

   // RULE_06 mode decode
   // Decoded from the written value, so mode and initiate may share one write
   wire logic [2:0] mode_wr = reg_wdata[FIAP_BIT_MODE_LSB +: 3];
   fiap_op_t op_sel;
   always_comb begin
      op_sel = FIAP_OP_NONE;
      if (mode_wr == FIAP_MODE_WRITE) op_sel = FIAP_OP_WRITE;
      else if (mode_wr == FIAP_MODE_ERASE) op_sel = FIAP_OP_ERASE;
      else if (mode_wr == FIAP_MODE_READ) op_sel = FIAP_OP_READ;
   end

   // RULE_21 locked write or erase never started
   wire logic wr_go = wr_mode && reg_wdata[FIAP_BIT_WRITE_INIT] && !busy_reg && unlock_status_reg
                   && (op_sel == FIAP_OP_WRITE || op_sel == FIAP_OP_ERASE);
   // RULE_12 read needs enable
   wire logic rd_go = wr_mode && reg_wdata[FIAP_BIT_READ_INIT] && !busy_reg
                   && reg_wdata[FIAP_BIT_READ_ENABLE] && op_sel == FIAP_OP_READ;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         write_initiate_reg <= 1'b0;
         read_initiate_reg  <= 1'b0;
         busy_reg           <= 1'b0;
         flash_req          <= '0;
      end else if (clk_en) begin
         flash_req.start <= 1'b0;
         if (busy_reg && flash_done) begin
            // RULE_10 RULE_13 self clear on completion
            write_initiate_reg <= 1'b0;
            read_initiate_reg  <= 1'b0;
            busy_reg           <= 1'b0;
         end else if (wr_go || rd_go) begin
            // RULE_10 RULE_13 launch operation
            write_initiate_reg <= wr_go;
            read_initiate_reg  <= rd_go;
            busy_reg           <= 1'b1;
            flash_req.start    <= 1'b1;
            flash_req.op       <= op_sel;
            flash_req.addr     <= 15'(addr_reg);
         end
      end
   end

   // RULE_11 stall while initiate bits set
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_stall <= 1'b0;
      end else if (clk_en) begin
         cpu_stall <= (wr_go || rd_go) || (busy_reg && !flash_done);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write buffer control
   // Clearing takes one cycle, so the bit reads one for exactly one cycle.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buffer_clear_reg <= 1'b0;
         buf_rsv7_reg     <= 1'b0;
         buf_rsv4_reg     <= 1'b0;
         wbuf             <= '0;
      end else if (clk_en) begin
         wbuf.load  <= 1'b0;
         wbuf.clear <= 1'b0;
         if (buffer_clear_reg) begin
            // RULE_16 clear done, bit drops
            buffer_clear_reg <= 1'b0;
         end else if (wr_en && reg_idx == FIAP_IDX_BUF_CTRL) begin
            buffer_clear_reg <= reg_wdata[FIAP_BIT_BUF_CLEAR];
            wbuf.clear       <= reg_wdata[FIAP_BIT_BUF_CLEAR];
            buf_rsv7_reg     <= reg_wdata[FIAP_BIT_BUF_RSV7];
            buf_rsv4_reg     <= reg_wdata[FIAP_BIT_BUF_RSV4];
         end
         if (busy_reg && flash_done && flash_req.op == FIAP_OP_WRITE) begin
            // RULE_19 auto clear after write
            wbuf.clear <= 1'b1;
         end
         if (wr_w0h && unlock_status_reg) begin
            // RULE_03 load both bytes
            wbuf.load  <= 1'b1;
            wbuf.index <= 6'(page_off);
            wbuf.data  <= {reg_wdata, data_low_reg[0]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = FIAP_RESET_VAL;
      unique case (reg_idx)
         FIAP_IDX_ADDR_LOW:  rd_mux = addr_reg[7:0];
         // RULE_01 upper bits zero
         FIAP_IDX_ADDR_HIGH: rd_mux = 8'(addr_reg[ADDR_W-1:8]);
         FIAP_IDX_W0_LOW:    rd_mux = data_low_reg[0];
         FIAP_IDX_W0_HIGH:   rd_mux = data_high_reg[0];
         FIAP_IDX_W1_LOW:    rd_mux = data_low_reg[1];
         FIAP_IDX_W1_HIGH:   rd_mux = data_high_reg[1];
         FIAP_IDX_W2_LOW:    rd_mux = data_low_reg[2];
         FIAP_IDX_W2_HIGH:   rd_mux = data_high_reg[2];
         FIAP_IDX_W3_LOW:    rd_mux = data_low_reg[3];
         FIAP_IDX_W3_HIGH:   rd_mux = data_high_reg[3];
         FIAP_IDX_MODE_CTRL: rd_mux = {unlock_status_reg, mode_reg, unlock_trigger_reg,
                                       write_initiate_reg, read_enable_reg, read_initiate_reg};
         // RULE_15 bits 6, 5, 3..1 read zero
         FIAP_IDX_BUF_CTRL:  rd_mux = {buf_rsv7_reg, 2'b00, buf_rsv4_reg, 3'b000, buffer_clear_reg};
         default:            rd_mux = FIAP_RESET_VAL;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= FIAP_RESET_VAL;
      end else if (clk_en && reg_rd) begin
         reg_rdata <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   a_status_needs_key: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
      $rose(unlock_status_reg) |-> $past(unlock_trigger_reg) && $past(key_ok))
      else $error("Unlock status set without valid pattern");
   a_trigger_window: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
      $fell(unlock_trigger_reg) |-> $past(timer_reg) == 24'(UNLOCK_CYCLES - 1))
      else $error("Trigger cleared at wrong time");
   a_locked_no_write: assert property (@(posedge clk) disable iff (!rst_n) // RULE_21
      flash_req.start && flash_req.op != FIAP_OP_READ |-> $past(unlock_status_reg))
      else $error("Write or erase started while locked");
   a_stall_follows: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
      flash_req.start |-> cpu_stall)
      else $error("No stall during operation");
   a_page_stop: assert property (@(posedge clk) disable iff (!rst_n) // RULE_20
      $past(wr_w0h) && $past(page_off) == {PAGE_BITS{1'b1}} && $past(clk_en) |-> $stable(addr_reg))
      else $error("Address crossed page");
   a_clear_pulse: assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
      buffer_clear_reg && clk_en |=> !buffer_clear_reg)
      else $error("Buffer clear bit stuck");
   a_read_enable: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
      flash_req.start && flash_req.op == FIAP_OP_READ |-> read_enable_reg)
      else $error("Read started without enable");
   a_high_zero: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
      reg_rd && clk_en && reg_idx == FIAP_IDX_ADDR_HIGH |=> (reg_rdata >> ADDR_HIGH_BITS) == 8'h00)
      else $error("Unimplemented address bits nonzero");
   a_status_clear: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
      wr_mode && !reg_wdata[FIAP_BIT_UNLOCK_STATUS] && !(unlock_trigger_reg && mode_reg == FIAP_MODE_UNLOCK && key_ok) |=> !unlock_status_reg)
      else $error("Unlock status not cleared by zero write");
   a_load_unlocked: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
      wbuf.load |-> $past(unlock_status_reg))
      else $error("Buffer loaded while locked");
   a_stall_initiate: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
      write_initiate_reg || read_initiate_reg |-> cpu_stall)
      else $error("Initiate bit set without stall");
   a_buf_zero_bits: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
      reg_rd && clk_en && reg_idx == FIAP_IDX_BUF_CTRL |=> reg_rdata[6:5] == 2'b00 && reg_rdata[3:1] == 3'b000)
      else $error("Buffer control unused bits nonzero");
   a_op_clear: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
      busy_reg && flash_done && clk_en |=> !write_initiate_reg && !read_initiate_reg)
      else $error("Initiate bit not cleared on completion");
endmodule : fiap_regs

/* File: tb/fiap_regs_bench.sv */
/*
 * Self-checking bench for the flash self-programming register block.
 * Assumes the block answers each start with a wait for flash_done, which the bench pulses itself.
 */
module fiap_regs_bench
   import fiap_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int UNLOCK_SIM = 50;
   // Whole run needs well under a thousand cycles
   localparam int TIMEOUT    = 5000;

   logic            clk;
   logic            rst_b;
   logic            clk_en;
   logic            reg_wr;
   logic            reg_rd;
   logic [3:0]      reg_idx;
   logic [7:0]      reg_wdata;
   logic [7:0]      reg_rdata;
   logic            flash_done;
   logic [15:0]     flash_rdata;
   fiap_flash_req_t flash_req;
   fiap_wbuf_t      wbuf;
   logic            cpu_stall;
   int              n_mismatch;
   int              checks;
   int              cycle_count;

   fiap_regs #(.ADDR_HIGH_BITS(5), .PAGE_BITS(5), .UNLOCK_CYCLES(UNLOCK_SIM)) uut (
      .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .flash_done(flash_done),
      .flash_rdata(flash_rdata), .flash_req(flash_req), .wbuf(wbuf), .cpu_stall(cpu_stall));

   always #50 clk = ~clk;

   always @(posedge clk) begin
      cycle_count <= cycle_count + 1;
      if (cycle_count == TIMEOUT) begin
         n_mismatch++;
         $display("unexpected at %0t: run did not finish", $time);
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("mismatches %0d, comparisons %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] idx, input logic [7:0] data);
      @(posedge clk);
      #10;
      reg_wr    = 1'b1;
      reg_idx   = idx;
      reg_wdata = data;
      @(posedge clk);
      #10;
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
      @(posedge clk);
      #10;
      reg_rd  = 1'b1;
      reg_idx = idx;
      @(posedge clk);
      #10;
      reg_rd = 1'b0;
      chk({8'h00, reg_rdata}, {8'h00, exp}, "read data");
   endtask : rd_chk

   task automatic finish_op(input logic [15:0] data);
      @(posedge clk);
      #10;
      flash_done  = 1'b1;
      flash_rdata = data;
      @(posedge clk);
      #10;
      flash_done = 1'b0;
   endtask : finish_op

   task automatic chk_start(input logic exp_start, input fiap_op_t exp_op);
      chk({15'h0, flash_req.start}, {15'h0, exp_start}, "start pulse");
      if (exp_start) chk({14'h0, flash_req.op}, {14'h0, exp_op}, "operation");
   endtask : chk_start

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values();
      for (int i = 0; i < 13; i++) rd_chk(4'(i), FIAP_RESET_VAL);
      wr(FIAP_IDX_ADDR_HIGH, 8'hff);
      rd_chk(FIAP_IDX_ADDR_HIGH, 8'h1f);
      wr(FIAP_IDX_ADDR_HIGH, 8'h00);
      for (int i = 4; i < 10; i++) wr(4'(i), 8'ha0 + 8'(i));
      for (int i = 4; i < 10; i++) rd_chk(4'(i), 8'ha0 + 8'(i));
   endtask : t_reset_values

   task automatic t_unlock();
      logic [3:0] idx[6];
      logic [7:0] key[6];
      idx = '{FIAP_IDX_W1_LOW, FIAP_IDX_W2_LOW, FIAP_IDX_W3_LOW, FIAP_IDX_W1_HIGH, FIAP_IDX_W2_HIGH,
              FIAP_IDX_W3_HIGH};
      key = '{8'h00, 8'h0d, 8'hc3, 8'h04, 8'h09, 8'h40};
      wr(FIAP_IDX_MODE_CTRL, 8'h80);
      rd_chk(FIAP_IDX_MODE_CTRL, 8'h00);
      wr(FIAP_IDX_MODE_CTRL, 8'h68);
      repeat (20) @(posedge clk);
      rd_chk(FIAP_IDX_MODE_CTRL, 8'h68);
      repeat (40) @(posedge clk);
      rd_chk(FIAP_IDX_MODE_CTRL, 8'h60);
      // Correct pattern written with no timer running must not unlock
      for (int i = 0; i < 6; i++) wr(idx[i], key[i]);
      rd_chk(FIAP_IDX_MODE_CTRL, 8'h60);
      // Spoiled byte keeps the trigger from unlocking until rewritten in the window
      wr(FIAP_IDX_W1_HIGH, 8'hff);
      wr(FIAP_IDX_MODE_CTRL, 8'h68);
      rd_chk(FIAP_IDX_MODE_CTRL, 8'h68);
      wr(FIAP_IDX_W1_HIGH, 8'h04);
      rd_chk(FIAP_IDX_MODE_CTRL, 8'he8);
      repeat (60) @(posedge clk);
      rd_chk(FIAP_IDX_MODE_CTRL, 8'he0);
   endtask : t_unlock

   task automatic t_wbuf_load();
      wr(FIAP_IDX_ADDR_LOW, 8'h1e);
      wr(FIAP_IDX_W0_LOW, 8'h34);
      chk({15'h0, wbuf.load}, 16'h0, "load on low byte");
      wr(FIAP_IDX_W0_HIGH, 8'h12);
      chk({15'h0, wbuf.load}, 16'h1, "load on high byte");
      chk(wbuf.data, 16'h1234, "buffer word");
      chk({10'h0, wbuf.index}, 16'h001e, "buffer index");
      rd_chk(FIAP_IDX_ADDR_LOW, 8'h1f);
      wr(FIAP_IDX_W0_HIGH, 8'h56);
      rd_chk(FIAP_IDX_ADDR_LOW, 8'h1f);
   endtask : t_wbuf_load

   task automatic t_operations();
      wr(FIAP_IDX_MODE_CTRL, 8'h84);
      chk_start(1'b1, FIAP_OP_WRITE);
      chk({1'b0, flash_req.addr}, 16'h001f, "operation address");
      repeat (3) @(posedge clk);
      chk({15'h0, cpu_stall}, 16'h1, "stall in write");
      finish_op(16'h0000);
      chk({15'h0, wbuf.clear}, 16'h1, "clear after write");
      chk({15'h0, cpu_stall}, 16'h0, "stall after write");
      rd_chk(FIAP_IDX_MODE_CTRL, 8'h80);
      wr(FIAP_IDX_MODE_CTRL, 8'h94);
      chk_start(1'b1, FIAP_OP_ERASE);
      finish_op(16'h0000);
      rd_chk(FIAP_IDX_MODE_CTRL, 8'h90);
      wr(FIAP_IDX_MODE_CTRL, 8'hb3);
      chk_start(1'b1, FIAP_OP_READ);
      repeat (2) @(posedge clk);
      chk({15'h0, cpu_stall}, 16'h1, "stall in read");
      finish_op(16'hbeef);
      rd_chk(FIAP_IDX_MODE_CTRL, 8'hb2);
      rd_chk(FIAP_IDX_W0_LOW, 8'hef);
      rd_chk(FIAP_IDX_W0_HIGH, 8'hbe);
   endtask : t_operations

   task automatic t_refusals();
      wr(FIAP_IDX_MODE_CTRL, 8'hb1);
      chk_start(1'b0, FIAP_OP_NONE);
      wr(FIAP_IDX_MODE_CTRL, 8'ha4);
      chk_start(1'b0, FIAP_OP_NONE);
      wr(FIAP_IDX_MODE_CTRL, 8'h00);
      rd_chk(FIAP_IDX_MODE_CTRL, 8'h00);
      wr(FIAP_IDX_MODE_CTRL, 8'h04);
      chk_start(1'b0, FIAP_OP_NONE);
      rd_chk(FIAP_IDX_MODE_CTRL, 8'h00);
      wr(FIAP_IDX_BUF_CTRL, 8'h6f);
      chk({15'h0, wbuf.clear}, 16'h1, "buffer clear");
      rd_chk(FIAP_IDX_BUF_CTRL, 8'h00);
      // A write with the clock enable low must leave the word untouched
      clk_en = 1'b0;
      wr(FIAP_IDX_W2_LOW, 8'h5a);
      clk_en = 1'b1;
      rd_chk(FIAP_IDX_W2_LOW, 8'h0d);
   endtask : t_refusals

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk         = 1'b0;
      rst_b       = 1'b0;
      clk_en      = 1'b1;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      reg_idx     = 4'h0;
      reg_wdata   = 8'h00;
      flash_done  = 1'b0;
      flash_rdata = 16'h0000;
      n_mismatch  = 0;
      checks      = 0;
      cycle_count = 0;
      repeat (16) @(posedge clk);
      #10;
      rst_b = 1'b1;
      // Internal reset copy needs two edges to release
      repeat (3) @(posedge clk);
      t_reset_values();
      t_unlock();
      t_wbuf_load();
      t_operations();
      t_refusals();
      complete_run();
   end
endmodule : fiap_regs_bench
